// *** lsi_pkg.sv ***
// Package for the LED status indicator channel: register layout and timing.
// Assumes a single 40 MHz system clock and a plain address/strobe register port.
package lsi_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] LED3_STATUS_CONTROL_ADDR = 4'h0;
    localparam logic [3:0] LINK_STATUS_REGISTER_ADDR = 4'h4;
    localparam logic [31:0] LED3_STATUS_CONTROL_RESET = 32'h0000_0090;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int COLLISION_ENABLE_BIT = 0;
    localparam int JABBER_ENABLE_BIT = 1;
    localparam int RX_ACTIVITY_ENABLE_BIT = 2;
    localparam int RX_POLARITY_ENABLE_BIT = 3;
    localparam int TX_ACTIVITY_ENABLE_BIT = 4;
    localparam int STRETCH_ENABLE_BIT = 7;
    localparam int INDICATOR_FLOAT_BIT = 13;
    localparam int INDICATOR_DRIVE_POLARITY_BIT = 14;
    localparam int INDICATOR_STATE_BIT = 15;
    localparam int LINK_PASS_FLAG_BIT = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int HEARTBEAT_WINDOW_NS = 4000;
    // Longest time: round down
    localparam int HEARTBEAT_WINDOW_CYCLES = (HEARTBEAT_WINDOW_NS * (CLK_FREQ_HZ / 1_000_000)) / 1000;
    localparam int STRETCH_CYCLES = 4000;
    localparam int CNT_W = 12;

    typedef enum logic [1:0] {
        LSI_IDLE = 2'b00,
        LSI_STRETCH = 2'b01
    } lsi_stretch_state_t;
endpackage

// *** lsi_stretch.sv ***
// Pulse stretcher for the LED indication.
// Assumes event is synchronous to clk_sys; restarts on each rising edge of event.
module lsi_stretch
    import lsi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic event_in,
    output logic stretched
);
    logic event_d;
    logic [CNT_W-1:0] count;
    lsi_stretch_state_t state;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            event_d <= 1'b0;
        end else begin
            event_d <= event_in;
        end
    end

    // New occurrence reloads the interval
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state <= LSI_IDLE;
            count <= '0;
        end else if (event_in && !event_d) begin
            state <= LSI_STRETCH;
            count <= CNT_W'(STRETCH_CYCLES - 1);
        end else begin
            case (state)
                LSI_IDLE: begin
                    count <= '0;
                end
                LSI_STRETCH: begin
                    if (count == '0) begin
                        state <= LSI_IDLE;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                default: begin
                    state <= LSI_IDLE;
                end
            endcase
        end
    end

    assign stretched = event_in || (state == LSI_STRETCH);
endmodule

// *** lsi_led_channel.sv ***
// LED status indicator channel: source OR, drive polarity, float and stretch.
// Assumes all status inputs are synchronous to clk_sys and the host uses
// one-cycle strobes with read data in the following cycle.
//
// Our own choices: the register offsets and the strobed register port.
module lsi_led_channel
    import lsi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic jabber,
    input wire logic collision,
    input wire logic rx_pol_reversed,
    input wire logic aui_selected,
    input wire logic link_pass_flag,
    input wire logic indicator_pin_three_in,
    output logic indicator_pin_three_out,
    output logic indicator_pin_three_oe
);
    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [15:0] ctrl;
    logic indicator_state;
    logic tx_d;
    logic [CNT_W-1:0] hb_count;
    logic collision_q;
    logic or_raw;
    logic drive_val;
    logic next_oe;
    logic next_out;

    // Reserved bits 12:8 are not stored, so they read as zero; reserved bits 6:5 are stored and read back
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= LED3_STATUS_CONTROL_RESET[15:0];
        end else if (reg_wr && reg_addr == LED3_STATUS_CONTROL_ADDR) begin
            ctrl <= {1'b0, reg_wdata[14:13], 5'h00, reg_wdata[7:0]};
        end
    end

    // ------------------------------------------------------------
    // Heartbeat window after transmit
    // ------------------------------------------------------------
    // Collision after transmit on AUI is the heartbeat test, not a real one
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tx_d <= 1'b0;
            hb_count <= '0;
        end else begin
            tx_d <= tx_active;
            // The falling-edge cycle itself is the first masked cycle
            if (tx_d && !tx_active) begin
                hb_count <= CNT_W'(HEARTBEAT_WINDOW_CYCLES - 1);
            end else if (hb_count != '0) begin
                hb_count <= hb_count - 1'b1;
            end
        end
    end

    always_comb begin
        collision_q = collision
            && !(aui_selected && (hb_count != '0 || (tx_d && !tx_active)));
        or_raw = (ctrl[TX_ACTIVITY_ENABLE_BIT] && tx_active)
            || (ctrl[RX_ACTIVITY_ENABLE_BIT] && rx_active)
            || (ctrl[JABBER_ENABLE_BIT] && jabber)
            || (ctrl[RX_POLARITY_ENABLE_BIT] && rx_pol_reversed && link_pass_flag)
            || (ctrl[COLLISION_ENABLE_BIT] && collision_q);
    end

    // ------------------------------------------------------------
    // Status bit: no reset, so it keeps following the sources every cycle, in reset too
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        indicator_state <= or_raw;
    end

    // ------------------------------------------------------------
    // Stretch and pin drive
    // ------------------------------------------------------------
    logic stretched;

    lsi_stretch u_stretch (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .event_in(or_raw),
        .stretched(stretched)
    );

    always_comb begin
        drive_val = ctrl[STRETCH_ENABLE_BIT] ? stretched : or_raw;
        if (ctrl[INDICATOR_FLOAT_BIT]) begin
            next_oe = 1'b0;
            next_out = 1'b0;
        end else if (ctrl[INDICATOR_DRIVE_POLARITY_BIT]) begin
            next_oe = 1'b1;
            next_out = drive_val;
        end else begin
            next_oe = drive_val;
            next_out = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            indicator_pin_three_oe <= 1'b0;
            indicator_pin_three_out <= 1'b0;
        end else begin
            indicator_pin_three_oe <= next_oe;
            indicator_pin_three_out <= next_out;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Pin input unused: the channel never samples its own pin
    logic unused_pin;
    assign unused_pin = indicator_pin_three_in;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                LED3_STATUS_CONTROL_ADDR: begin
                    reg_rdata <= {16'h0000, indicator_state, ctrl[14:0]};
                end
                LINK_STATUS_REGISTER_ADDR: begin
                    reg_rdata <= {31'h0, link_pass_flag};
                end
                default: begin
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end
endmodule

// *** lsi_properties.sv ***
// Concurrent checks on the LED channel ports.
// Assumes it is bound to lsi_led_channel; it mirrors the control register.
module lsi_chk
    import lsi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic jabber,
    input wire logic collision,
    input wire logic rx_pol_reversed,
    input wire logic aui_selected,
    input wire logic link_pass_flag,
    input wire logic indicator_pin_three_out,
    input wire logic indicator_pin_three_oe
);
    logic [31:0] sh;
    wire oe = indicator_pin_three_oe;
    wire po = indicator_pin_three_out;
    wire rd0 = reg_rd && reg_addr == LED3_STATUS_CONTROL_ADDR;
    wire drv0 = ~sh[13] & ~sh[14];
    wire drv1 = ~sh[13] & sh[14] & ~sh[7];
    // Collision under AUI may sit in the heartbeat window: left open here
    wire unk = sh[0] & collision & aui_selected;
    wire raw = |(sh[4:1] & {tx_active, rx_pol_reversed & link_pass_flag, rx_active, jabber})
        | (sh[0] & collision & ~aui_selected);
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sh <= LED3_STATUS_CONTROL_RESET;
        end else if (reg_wr && reg_addr == LED3_STATUS_CONTROL_ADDR) begin
            sh <= reg_wdata & 32'h0000_60ff;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_ctrl_readback: assert property ($past(rd0) |->
        {reg_rdata[31:16], reg_rdata[14:0]} == {16'h0, $past(sh[14:0])}) else $error("bad read");
    a_state_read: assert property ($past(rd0) && !$past(unk) && $past(raw) == $past(raw, 2)
        && $past(raw, 2) == $past(raw, 3) |-> reg_rdata[15] == $past(raw)) else $error("bad state");
    a_tx_lights: assert property ($past(sh[4]) && $past(tx_active) && !$past(sh[13]) |-> oe)
        else $error("transmit not shown");
    a_float_release: assert property ($past(sh[13]) |-> !oe) else $error("pin driven");
    a_drain_low: assert property ($past(raw) && $past(drv0) |-> oe && !po)
        else $error("pin not pulled low");
    a_drain_float: assert property ($past(drv0) && !$past(sh[7]) && !$past(raw) && !$past(unk)
        |-> !oe) else $error("pin not released");
    a_push_pull: assert property ($past(drv1) && !$past(unk) |-> oe && po == $past(raw))
        else $error("push-pull level wrong");
    a_stretch_hold: assert property ($past(drv0) && $past(sh[7]) && !$past(raw) && $past(raw, 2)
        |-> oe) else $error("stretch missing");
endmodule
bind lsi_led_channel lsi_chk i_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_active(tx_active), .rx_active(rx_active), .jabber(jabber), .collision(collision),
    .rx_pol_reversed(rx_pol_reversed), .aui_selected(aui_selected),
    .link_pass_flag(link_pass_flag),
    .indicator_pin_three_out(indicator_pin_three_out),
    .indicator_pin_three_oe(indicator_pin_three_oe));

// *** lsi_led_model.sv ***
// LED on the indicator pin with a pull-up to supply.
// Assumes the channel drives the pin value and its output enable.
module lsi_led_model (
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule

// *** lsi_tb.sv ***
// Bench for the LED channel: register and pin tests over the strobe port.
// Assumes the checker is bound in and the LED model sits on the pin.
module testbench
    import lsi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] CA = LED3_STATUS_CONTROL_ADDR;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [4:0] src = 5'h0;
    logic aui_selected = 1'b0;
    logic link_pass_flag = 1'b1;
    logic [31:0] reg_rdata;
    logic pin_out;
    logic pin_oe;
    logic pin_level;
    int n_mismatch = 0;
    int n_compared = 0;
    always #12.5 clk_sys = ~clk_sys;
    lsi_led_channel i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_active(src[4]), .rx_pol_reversed(src[3]), .rx_active(src[2]), .jabber(src[1]),
        .collision(src[0]), .aui_selected(aui_selected), .link_pass_flag(link_pass_flag),
        .indicator_pin_three_in(pin_level), .indicator_pin_three_out(pin_out),
        .indicator_pin_three_oe(pin_oe));
    lsi_led_model i_led (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Pin code {oe, level}: 1 dark and floating, 2 driven low, 3 driven high
    task automatic wait_chk(input int n, input logic [31:0] exp);
        repeat (n) @(posedge clk_sys);
        #1 chk({30'h0, pin_oe, pin_level}, exp);
    endtask
    task automatic drive(input logic [4:0] v, input logic [31:0] exp);
        @(posedge clk_sys);
        src <= v;
        wait_chk(3, exp);
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(CA, 32'h0000_0090);
        rd(4'h8, 32'h0);
        rd(LINK_STATUS_REGISTER_ADDR, 32'h1);
        wr(CA, 32'h0000_e0ff);
        rd(CA, 32'h0000_60ff);
        drive(5'h1f, 32'h1);
        rd(CA, 32'h0000_e0ff);
        for (int i = 0; i < 5; i++) begin
            wr(CA, 32'h1 << i);
            drive(~(5'h1 << i), 32'h1);
            drive(5'h1 << i, 32'h2);
            rd(CA, 32'h8000 | (32'h1 << i));
        end
        // Reversed polarity counts only while the link passes
        wr(CA, 32'h0000_0008);
        @(posedge clk_sys);
        link_pass_flag <= 1'b0;
        drive(5'h08, 32'h1);
        rd(CA, 32'h0000_0008);
        @(posedge clk_sys);
        link_pass_flag <= 1'b1;
        wr(CA, 32'h0000_001f);
        drive(5'h0a, 32'h2);
        wr(CA, 32'h0000_4010);
        drive(5'h10, 32'h3);
        rd(CA, 32'h0000_c010);
        drive(5'h00, 32'h2);
        @(posedge clk_sys);
        aui_selected <= 1'b1;
        wr(CA, 32'h0000_0001);
        drive(5'h10, 32'h1);
        // Collision in the very cycle after transmit ends must stay dark
        @(posedge clk_sys);
        src <= 5'h01;
        wait_chk(1, 32'h1);
        wait_chk(2, 32'h1);
        drive(5'h00, 32'h1);
        wait_chk(200, 32'h1);
        drive(5'h01, 32'h2);
        drive(5'h00, 32'h1);
        wr(CA, LED3_STATUS_CONTROL_RESET);
        drive(5'h10, 32'h2);
        drive(5'h00, 32'h2);
        wait_chk(3000, 32'h2);
        drive(5'h10, 32'h2);
        drive(5'h00, 32'h2);
        wait_chk(3500, 32'h2);
        wait_chk(700, 32'h1);
        report_and_stop();
    end
endmodule
